/* hdl/srm_baud_gen.v */
// Fractional baud divider producing the receive oversampling tick.
`timescale 1ns/1ps
`include "srm_defines.vh"
module srm_baud_gen
(
   input  wire        mclk_i,
   input  wire        reset_i,
   input  wire        run_i,
   input  wire [15:0] divider_i,
   output reg         tick_o
);
   // ------------------------------------------------------------------------
   // Accumulator in sixteenths of a clock
   // ------------------------------------------------------------------------
   // A divider below one whole clock is raised to one so the tick never stalls.
   wire [16:0] div_w = ({1'b0, divider_i} < `SRM_DIV_MIN) ? `SRM_DIV_MIN : {1'b0, divider_i};
   reg  [16:0] acc_q;
   wire [16:0] sum_w = acc_q + `SRM_ACC_STEP;

   always @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         acc_q  <= 17'h00000;
         tick_o <= 1'b0;
      end
      else if (!run_i)
      begin
         acc_q  <= 17'h00000;
         tick_o <= 1'b0;
      end
      else if (sum_w >= div_w)
      begin
         acc_q  <= sum_w - div_w; // [R15]
         tick_o <= 1'b1;
      end
      else
      begin
         acc_q  <= sum_w;
         tick_o <= 1'b0;
      end
   end
endmodule

/* hdl/srm_break_det.v */
// Line break detector that watches the receive line independently of the receiver.
`timescale 1ns/1ps
`include "srm_defines.vh"
module srm_break_det
(
   input  wire mclk_i,
   input  wire reset_i,
   input  wire enable_i,
   input  wire long_i,
   input  wire tick_i,
   input  wire rx_i,
   output reg  detect_o
);
   reg  [7:0] cnt_q;
   reg        armed_q;
   wire [7:0] thr_w = long_i ? `SRM_BRK_TICKS11 : `SRM_BRK_TICKS10;

   // One pulse per low stretch; a high sample re-arms the detector.
   always @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         cnt_q    <= 8'h00;
         armed_q  <= 1'b1;
         detect_o <= 1'b0;
      end
      else if (!enable_i || rx_i)
      begin
         cnt_q    <= 8'h00;
         armed_q  <= 1'b1;
         detect_o <= 1'b0;
      end
      else if (tick_i && armed_q)
      begin
         if (cnt_q == thr_w - 8'h01)
         begin
            detect_o <= 1'b1; // [R21]
            armed_q  <= 1'b0;
         end
         else
         begin
            cnt_q    <= cnt_q + 8'h01;
            detect_o <= 1'b0;
         end
      end
      else
      begin
         detect_o <= 1'b0;
      end
   end
endmodule

/* hdl/srm_defines.vh */
// Constants of the serial receiver: offsets, field positions, reset values and sample counts.
`ifndef SRM_DEFINES_VH
`define SRM_DEFINES_VH
// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define SRM_ADDR_STATUS 8'h00
`define SRM_ADDR_DATA   8'h04
`define SRM_ADDR_BAUD   8'h08
`define SRM_ADDR_CTRL1  8'h0C
`define SRM_ADDR_CTRL2  8'h10
// ----------------------------------------------------------------------------
// Status register bits
// ----------------------------------------------------------------------------
`define SRM_ST_PE   0
`define SRM_ST_FE   1
`define SRM_ST_NE   2
`define SRM_ST_OVR  3
`define SRM_ST_IDLE 4
`define SRM_ST_RXF  5
`define SRM_ST_BRK  8
// ----------------------------------------------------------------------------
// Control register 1 bits
// ----------------------------------------------------------------------------
`define SRM_C1_PORT_EN 0
`define SRM_C1_RX_EN   1
`define SRM_C1_MUTE    2
`define SRM_C1_WAKE    3
`define SRM_C1_ODD     4
`define SRM_C1_PAR_EN  5
`define SRM_C1_WL9     6
`define SRM_C1_OS8     7
`define SRM_C1_RXF_IE  8
`define SRM_C1_IDLE_IE 9
`define SRM_C1_ERR_IE  10
`define SRM_C1_BRK_IE  11
`define SRM_C1_DMA_EN  12
`define SRM_C1_W       13
// ----------------------------------------------------------------------------
// Control register 2 fields
// ----------------------------------------------------------------------------
`define SRM_C2_ADDR_HI 3
`define SRM_C2_SYNC_EN 4
`define SRM_C2_CLOCK_IDLE_LEVEL    5
`define SRM_C2_CLOCK_SAMPLE_EDGE    6
`define SRM_C2_LASTCLK 7
`define SRM_C2_LIN_EN  8
`define SRM_C2_BRK11   9
`define SRM_C2_SC_EN   10
`define SRM_C2_W       11
// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define SRM_C1_RESET   13'h0000
`define SRM_C2_RESET   11'h000
`define SRM_BAUD_RESET 16'h0000
`define SRM_DIV_MIN    17'h00010
`define SRM_ACC_STEP   17'h00010
`define SRM_LAST16     5'h0F
`define SRM_LAST8      5'h07
`define SRM_MID16      5'h08
`define SRM_MID8       5'h04
`define SRM_BITS8      4'h8
`define SRM_BITS9      4'h9
`define SRM_BRK_TICKS10 8'hA0
`define SRM_BRK_TICKS11 8'hB0
`endif

/* hdl/srm_receiver.v */
// Serial receiver with mute, synchronous clock, line break and smart card handling, on APB.
// Behaviour
// [R01] Software keeps the receiver enabled while a character is arriving.
// [R02] Smart card parity error: pull data low half bit after frame, one bit long.
// [R03] Completed character sets receive-full flag; interrupt when its enable is set.
// [R04] Single buffer: data read or writing zero clears receive-full.
// [R05] DMA mode: flag set per byte, cleared when DMA reads data.
// [R06] An all-zero break frame is reported as a framing error.
// [R07] Idle frame handled like a frame; idle detection interrupts when enabled.
// [R08] Oversample select picks 8 or 16 samples per bit.
// [R09] Character completing while receive-full set raises overrun and its interrupt.
// [R10] On overrun the stored data stays and the new character is dropped.
// [R11] Overrun clears by reading status then data.
// [R12] Noise flag rises with receive-full; noisy character is still stored.
// [R13] Software avoids 8-sample mode with line break or smart card modes.
// [R14] Bad stop bit sets framing error; interrupt only in DMA mode if enabled.
// [R15] Sixteen-bit divider, 12 integer and 4 fraction bits, sets bit rate.
// [R16] While muted no receive flags are set and receive interrupts stay off; the code still sets the break flag while muted.
// [R17] Idle wake method: mute bit enters mute, idle frame clears it.
// [R18] Address wake: marked byte compares low nibble; match wakes, mismatch mutes.
// [R19] Sync clock pulses only during data bits.
// [R20] Last-bit pulse option, polarity and phase shape the sync clock.
// [R21] Line break detector with 10 or 11 bit threshold sets break flag.
// [R22] Break on idle line yields a zero character with framing error.
// [R23] Word length and parity enable select the frame layout.
// [R24] Parity select: even when clear, odd when set; characters checked.
// [R25] Majority of three centre samples; disagreement flags noise.
`timescale 1ns/1ps
`include "srm_defines.vh"
module srm_receiver
(
   input  wire        mclk_i,
   input  wire        reset_i,
   input  wire        psel_i,
   input  wire        penable_i,
   input  wire        pwrite_i,
   input  wire [7:0]  paddr_i,
   input  wire [31:0] pwdata_i,
   output reg  [31:0] prdata_o,
   output wire        pready_o,
   output wire        pslverr_o,
   input  wire        rx_i,
   output wire        sc_line_o,
   output reg         sc_line_oe_o,
   output reg         sync_clock_out_o,
   output wire        rx_dma_req_o,
   output wire        irq_o
);
   localparam ST_IDLE  = 3'h0;
   localparam ST_START = 3'h1;
   localparam ST_DATA  = 3'h2;
   localparam ST_STOP  = 3'h3;
   localparam ST_NACK  = 3'h4;

   // ------------------------------------------------------------------------
   // Registers and state
   // ------------------------------------------------------------------------
   reg  [`SRM_C1_W-1:0] ctrl1_q;
   reg  [`SRM_C2_W-1:0] ctrl2_q;
   reg  [15:0]          baud_q;
   reg  [8:0]           data_q;
   reg                  rxf_q;
   reg                  ovr_q;
   reg                  ne_q;
   reg                  fe_q;
   reg                  pe_q;
   reg                  idle_q;
   reg                  brk_q;
   reg                  seen_q;
   reg                  ack_q;
   reg                  rx_s1_q;
   reg                  rx_s2_q;
   reg                  rx_prev_q;
   reg  [2:0]           state_q;
   reg  [4:0]           smp_q;
   reg  [3:0]           bit_q;
   reg  [8:0]           shift_q;
   reg  [1:0]           vote_q;
   reg                  noise_q;
   reg                  force_fe_q;
   reg  [5:0]           nack_q;
   reg  [7:0]           idle_cnt_q;
   reg                  idle_armed_q;
   wire                 tick_w;
   wire                 brk_pulse_w;

   // ------------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------------
   function [4:0] last_smp;
      input os8;
      begin
         last_smp = os8 ? `SRM_LAST8 : `SRM_LAST16;
      end
   endfunction

   function [4:0] mid_smp;
      input os8;
      begin
         mid_smp = os8 ? `SRM_MID8 : `SRM_MID16;
      end
   endfunction

   wire       os8_w    = ctrl1_q[`SRM_C1_OS8]; // [R08]
   wire [4:0] last_w   = last_smp(os8_w);
   wire [4:0] mid_w    = mid_smp(os8_w);
   wire [3:0] nbits_w  = ctrl1_q[`SRM_C1_WL9] ? `SRM_BITS9 : `SRM_BITS8; // [R23]
   wire       active_w = ctrl1_q[`SRM_C1_PORT_EN] & ctrl1_q[`SRM_C1_RX_EN];
   wire       rx_w     = rx_s2_q;
   wire       mute_w   = ctrl1_q[`SRM_C1_MUTE];
   wire       wake_w   = ctrl1_q[`SRM_C1_WAKE];

   // Three-sample vote at the bit centre.
   wire maj_w   = (vote_q[0] & vote_q[1]) | (vote_q[0] & rx_w) | (vote_q[1] & rx_w); // [R25]
   wire noisy_w = ~((vote_q[0] == vote_q[1]) & (vote_q[1] == rx_w)); // [R25]
   wire in_frame_w = (state_q == ST_START) | (state_q == ST_DATA) | (state_q == ST_STOP);
   wire decide_w   = tick_w & in_frame_w & (smp_q == mid_w + 5'h01);
   wire bit_end_w  = tick_w & in_frame_w & (smp_q == last_w);
   wire done_w     = decide_w & (state_q == ST_STOP) & active_w;

   wire parity_bad_w = ctrl1_q[`SRM_C1_PAR_EN] & ((^shift_q) ^ ctrl1_q[`SRM_C1_ODD]); // [R24]
   wire frame_err_w  = ~maj_w | force_fe_q; // [R06] [R14] [R22]
   wire mark_w  = ctrl1_q[`SRM_C1_WL9] ? shift_q[8] : shift_q[7];
   wire is_addr_w = wake_w & mark_w; // [R18]
   wire match_w = (shift_q[3:0] == ctrl2_q[`SRM_C2_ADDR_HI:0]);
   wire accept_w = done_w & (is_addr_w ? match_w : ~mute_w); // [R16] [R18]

   wire [7:0] frame_ticks_w = {4'h0, nbits_w + 4'h2} * {3'h0, last_w + 5'h01};
   wire idle_evt_w = tick_w & active_w & (state_q == ST_IDLE) & rx_w & idle_armed_q &
                     (idle_cnt_q == frame_ticks_w - 8'h01);
   wire start_w = tick_w & active_w & (state_q == ST_IDLE) & rx_prev_q & ~rx_w;

   // ------------------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------------------
   wire acc_w   = psel_i & penable_i;
   wire fire_w  = acc_w & ack_q;
   wire mapped_w = (paddr_i == `SRM_ADDR_STATUS) | (paddr_i == `SRM_ADDR_DATA) |
                   (paddr_i == `SRM_ADDR_BAUD) | (paddr_i == `SRM_ADDR_CTRL1) |
                   (paddr_i == `SRM_ADDR_CTRL2);
   wire wr_w    = fire_w & pwrite_i;
   wire rd_st_w = fire_w & ~pwrite_i & (paddr_i == `SRM_ADDR_STATUS);
   wire rd_dt_w = fire_w & ~pwrite_i & (paddr_i == `SRM_ADDR_DATA);
   wire wr_st_w = wr_w & (paddr_i == `SRM_ADDR_STATUS);
   wire clr_err_w = rd_dt_w & seen_q; // [R11]

   assign pready_o  = ack_q;
   assign pslverr_o = ack_q & ~mapped_w;

   wire [31:0] status_w = {23'h000000, brk_q, 2'h0, rxf_q, idle_q, ovr_q, ne_q, fe_q, pe_q};
   reg  [31:0] rdata_w;
   always @*
   begin
      case (paddr_i)
         `SRM_ADDR_STATUS: rdata_w = status_w;
         `SRM_ADDR_DATA:   rdata_w = {23'h000000, data_q};
         `SRM_ADDR_BAUD:   rdata_w = {16'h0000, baud_q};
         `SRM_ADDR_CTRL1:  rdata_w = {19'h00000, ctrl1_q};
         `SRM_ADDR_CTRL2:  rdata_w = {21'h000000, ctrl2_q};
         default:          rdata_w = 32'h00000000;
      endcase
   end

   always @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         ack_q    <= 1'b0;
         prdata_o <= 32'h00000000;
      end
      else
      begin
         ack_q <= acc_w & ~ack_q;
         if (acc_w & ~ack_q)
         begin
            prdata_o <= pwrite_i ? 32'h00000000 : rdata_w;
         end
      end
   end

   // ------------------------------------------------------------------------
   // Control registers and mute state
   // ------------------------------------------------------------------------
   always @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         ctrl1_q <= `SRM_C1_RESET;
         ctrl2_q <= `SRM_C2_RESET;
         baud_q  <= `SRM_BAUD_RESET;
      end
      else
      begin
         if (wr_w & (paddr_i == `SRM_ADDR_BAUD))
         begin
            baud_q <= pwdata_i[15:0];
         end
         if (wr_w & (paddr_i == `SRM_ADDR_CTRL2))
         begin
            ctrl2_q <= pwdata_i[`SRM_C2_W-1:0];
         end
         if (wr_w & (paddr_i == `SRM_ADDR_CTRL1))
         begin
            ctrl1_q <= pwdata_i[`SRM_C1_W-1:0]; // [R17]
         end
         else if (done_w & is_addr_w)
         begin
            ctrl1_q[`SRM_C1_MUTE] <= ~match_w; // [R18]
         end
         else if (idle_evt_w & ~wake_w)
         begin
            ctrl1_q[`SRM_C1_MUTE] <= 1'b0; // [R17]
         end
      end
   end

   // ------------------------------------------------------------------------
   // Status flags
   // ------------------------------------------------------------------------
   always @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         data_q <= 9'h000;
         rxf_q  <= 1'b0;
         ovr_q  <= 1'b0;
         ne_q   <= 1'b0;
         fe_q   <= 1'b0;
         pe_q   <= 1'b0;
         idle_q <= 1'b0;
         brk_q  <= 1'b0;
         seen_q <= 1'b0;
      end
      else
      begin
         if (rd_st_w)
         begin
            seen_q <= 1'b1;
         end
         else if (rd_dt_w)
         begin
            seen_q <= 1'b0;
         end
         if (accept_w & ~rxf_q)
         begin
            data_q <= shift_q; // [R12] [R14]
            rxf_q  <= 1'b1; // [R03] [R05]
            ne_q   <= noise_q; // [R12]
            fe_q   <= frame_err_w; // [R06] [R14]
            pe_q   <= parity_bad_w; // [R24]
         end
         else
         begin
            if (rd_dt_w | (wr_st_w & ~pwdata_i[`SRM_ST_RXF]))
            begin
               rxf_q <= 1'b0; // [R04] [R05]
            end
            if (clr_err_w)
            begin
               ne_q <= 1'b0;
               fe_q <= 1'b0;
               pe_q <= 1'b0;
            end
         end
         if (accept_w & rxf_q)
         begin
            ovr_q <= 1'b1; // [R09] [R10]
         end
         else if (clr_err_w)
         begin
            ovr_q <= 1'b0; // [R11]
         end
         if (idle_evt_w & ~mute_w)
         begin
            idle_q <= 1'b1; // [R07] [R16]
         end
         else if (clr_err_w)
         begin
            idle_q <= 1'b0;
         end
         if (brk_pulse_w)
         begin
            brk_q <= 1'b1; // [R21]
         end
         else if (wr_st_w & ~pwdata_i[`SRM_ST_BRK])
         begin
            brk_q <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------------
   // Receive sequencer
   // ------------------------------------------------------------------------
   always @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rx_s1_q      <= 1'b1;
         rx_s2_q      <= 1'b1;
         rx_prev_q    <= 1'b1;
         state_q      <= ST_IDLE;
         smp_q        <= 5'h00;
         bit_q        <= 4'h0;
         shift_q      <= 9'h000;
         vote_q       <= 2'h0;
         noise_q      <= 1'b0;
         force_fe_q   <= 1'b0;
         nack_q       <= 6'h00;
         idle_cnt_q   <= 8'h00;
         idle_armed_q <= 1'b1;
      end
      else
      begin
         rx_s1_q <= rx_i;
         rx_s2_q <= rx_s1_q;
         if (tick_w)
         begin
            rx_prev_q <= rx_w;
         end
         if (brk_pulse_w & in_frame_w)
         begin
            force_fe_q <= 1'b1; // [R22]
         end
         if (tick_w & (state_q == ST_IDLE) & rx_w & (idle_cnt_q != frame_ticks_w))
         begin
            idle_cnt_q <= idle_cnt_q + 8'h01;
         end
         else if (tick_w & ~rx_w)
         begin
            idle_cnt_q <= 8'h00;
         end
         if (idle_evt_w)
         begin
            idle_armed_q <= 1'b0;
         end
         if (!active_w)
         begin
            state_q <= ST_IDLE; // [R01]
         end
         else
         begin
            case (state_q)
               ST_IDLE:
               begin
                  if (start_w)
                  begin
                     state_q      <= ST_START;
                     smp_q        <= 5'h01;
                     shift_q      <= 9'h000;
                     noise_q      <= 1'b0;
                     force_fe_q   <= 1'b0;
                     idle_armed_q <= 1'b1;
                  end
               end
               ST_START, ST_DATA, ST_STOP:
               begin
                  if (tick_w)
                  begin
                     smp_q <= (smp_q == last_w) ? 5'h00 : smp_q + 5'h01;
                  end
                  if (tick_w & (smp_q == mid_w - 5'h01))
                  begin
                     vote_q[0] <= rx_w;
                  end
                  if (tick_w & (smp_q == mid_w))
                  begin
                     vote_q[1] <= rx_w;
                  end
                  if (decide_w)
                  begin
                     noise_q <= noise_q | noisy_w; // [R25]
                  end
                  if (decide_w & (state_q == ST_START) & maj_w)
                  begin
                     state_q <= ST_IDLE;
                  end
                  else if (decide_w & (state_q == ST_DATA))
                  begin
                     shift_q[bit_q] <= maj_w;
                  end
                  else if (done_w)
                  begin
                     state_q <= (ctrl2_q[`SRM_C2_SC_EN] & parity_bad_w) ? ST_NACK : ST_IDLE; // [R02]
                     nack_q  <= 6'h00;
                  end
                  if (bit_end_w & (state_q == ST_START))
                  begin
                     state_q <= ST_DATA;
                     bit_q   <= 4'h0;
                  end
                  else if (bit_end_w & (state_q == ST_DATA))
                  begin
                     if (bit_q == nbits_w - 4'h1)
                     begin
                        state_q <= ST_STOP;
                     end
                     else
                     begin
                        bit_q <= bit_q + 4'h1;
                     end
                  end
               end
               ST_NACK:
               begin
                  if (tick_w)
                  begin
                     nack_q <= nack_q + 6'h01;
                  end
                  if (tick_w & (nack_q == {last_w, 1'b0}))
                  begin
                     state_q <= ST_IDLE;
                  end
               end
               default:
               begin
                  state_q <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // ------------------------------------------------------------------------
   // Smart card rejection and synchronous clock
   // ------------------------------------------------------------------------
   // The rejection pulse starts half a bit after the nominal stop end.
   wire nack_drive_w = (state_q == ST_NACK) & (nack_q >= {1'b0, last_w}); // [R02]
   wire last_bit_w   = (bit_q == nbits_w - 4'h1);
   wire clk_half_w   = ctrl2_q[`SRM_C2_CLOCK_SAMPLE_EDGE] ? (smp_q < mid_w) : (smp_q >= mid_w); // [R20]
   wire clk_pulse_w  = ctrl2_q[`SRM_C2_SYNC_EN] & (state_q == ST_DATA) & clk_half_w &
                       (~last_bit_w | ctrl2_q[`SRM_C2_LASTCLK]); // [R19] [R20]

   always @(posedge mclk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         sc_line_oe_o     <= 1'b0;
         sync_clock_out_o <= 1'b0;
      end
      else
      begin
         sc_line_oe_o     <= nack_drive_w;
         sync_clock_out_o <= ctrl2_q[`SRM_C2_CLOCK_IDLE_LEVEL] ^ clk_pulse_w;
      end
   end

   assign sc_line_o    = 1'b0;
   assign rx_dma_req_o = rxf_q & ctrl1_q[`SRM_C1_DMA_EN];

   // Receive interrupts are held off while muted.
   assign irq_o = ~mute_w & (((rxf_q | ovr_q) & ctrl1_q[`SRM_C1_RXF_IE]) | // [R03] [R09] [R16]
                  (idle_q & ctrl1_q[`SRM_C1_IDLE_IE]) | // [R07]
                  (brk_q & ctrl1_q[`SRM_C1_BRK_IE]) | // [R21]
                  ((fe_q | ne_q | ovr_q) & ctrl1_q[`SRM_C1_ERR_IE] & ctrl1_q[`SRM_C1_DMA_EN])); // [R14]

   // ------------------------------------------------------------------------
   // Sub-blocks
   // ------------------------------------------------------------------------
   srm_baud_gen u_baud
   (
      .mclk_i    (mclk_i),
      .reset_i   (reset_i),
      .run_i     (ctrl1_q[`SRM_C1_PORT_EN]),
      .divider_i (baud_q),
      .tick_o    (tick_w)
   );

   // Break thresholds assume 16 samples per bit; 8-sample mode is not used here.
   srm_break_det u_break
   (
      .mclk_i   (mclk_i),
      .reset_i  (reset_i),
      .enable_i (ctrl2_q[`SRM_C2_LIN_EN]),
      .long_i   (ctrl2_q[`SRM_C2_BRK11]),
      .tick_i   (tick_w),
      .rx_i     (rx_w),
      .detect_o (brk_pulse_w)
   ); // [R13]
endmodule

/* tb/srm_receiver_assertions.sv */
// Port checks bound to the serial receiver.
`timescale 1ns/1ps
module srm_receiver_checker
(
   input wire        mclk_i, reset_i, psel_i, penable_i, pwrite_i, rx_i,
   input wire [7:0]  paddr_i,
   input wire [31:0] pwdata_i, prdata_o,
   input wire        pready_o, pslverr_o, sc_line_o, sc_line_oe_o, sync_clock_out_o, rx_dma_req_o, irq_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   property p_wait; psel_i && !penable_i |=> !pready_o ##1 pready_o; endproperty
   a_wait: assert property (p_wait) else $error("wait state wrong");
   property p_pulse; pready_o |=> !pready_o; endproperty
   a_pulse: assert property (p_pulse) else $error("ready too long");
   property p_quiet; pready_o |-> psel_i && penable_i; endproperty
   a_quiet: assert property (p_quiet) else $error("ready outside access");
   property p_rd0; pready_o && pslverr_o && !pwrite_i |-> prdata_o == 32'h0; endproperty
   a_rd0: assert property (p_rd0) else $error("unmapped read not zero");
   property p_hold; rx_dma_req_o && !(pready_o && (pwrite_i || paddr_i == 8'h04)) |=> rx_dma_req_o; endproperty
   a_hold: assert property (p_hold) else $error("dma request lost");
   property p_dma; pready_o && !pwrite_i && paddr_i == 8'h04 |=> !rx_dma_req_o; endproperty
   a_dma: assert property (p_dma) else $error("dma request kept");
   property p_oe_len; $rose(sc_line_oe_o) |-> sc_line_oe_o [*8]; endproperty
   a_oe_len: assert property (p_oe_len) else $error("pull too short");
   property p_oe_end; $rose(sc_line_oe_o) |-> ##[8:1000] !sc_line_oe_o; endproperty
   a_oe_end: assert property (p_oe_end) else $error("pull not released");
endmodule
bind srm_receiver srm_receiver_checker i_srm_receiver_checker (.*);

/* tb/srm_receiver_tb.sv */
// Self-checking bench for the serial receiver.
`timescale 1ns/1ps
module srm_receiver_tb;
   localparam logic [31:0] SM = 32'h13F;
   logic        mclk_i, reset_i, psel_i, penable_i, pwrite_i, line;
   logic [7:0]  paddr_i;
   logic [31:0] pwdata_i, prdata_o;
   logic        pready_o, pslverr_o, sc_line_o, sc_line_oe_o, sync_clock_out_o, rx_dma_req_o, irq_o;
   logic [64:0] q[$];
   logic [64:0] e;
   logic [8:0]  d;
   int          err_count, checks_done, k, j, pulses;
   wire         rx_i = sc_line_oe_o ? sc_line_o : line;
   srm_receiver i_srm_receiver (.*);
   srm_serial_node i_srm_serial_node (.mclk_i(mclk_i), .line_o(line));
   initial
   begin
      mclk_i = 1'b0;
      forever #20 mclk_i = ~mclk_i;
   end
   task test_done;
      begin
         $display("checks %0d errors %0d", checks_done, err_count);
         if (err_count == 0 && checks_done > 0)
            $display("Regression OK");
         else
            $display("Regression broken");
         $finish;
      end
   endtask
   task chk(input logic got, input logic want);
      begin
         checks_done++;
         if (got !== want)
         begin
            err_count++;
            $display("CHECK FAILED %0t got %b want %b", $time, got, want);
         end
      end
   endtask
   always @(posedge sync_clock_out_o)
      pulses++;
   task apb(input logic w, input logic [7:0] a, input logic [31:0] v);
      int n;
      begin
         @(posedge mclk_i);
         {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, v};
         @(posedge mclk_i);
         penable_i <= 1'b1;
         for (n = 0; n < 20 && pready_o !== 1'b1; n++)
            @(posedge mclk_i);
         if (n == 20)
         begin
            err_count++;
            test_done;
         end
         {psel_i, penable_i} <= 2'b00;
      end
   endtask
   task rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input logic er);
      begin
         q.push_back({er, m, x});
         apb(1'b0, a, 32'h0);
      end
   endtask
   always @(posedge mclk_i)
      if (psel_i && penable_i && pready_o === 1'b1 && !pwrite_i && q.size() > 0)
      begin
         e = q.pop_front();
         checks_done++;
         if ({pslverr_o, prdata_o & e[63:32]} !== {e[64], e[31:0]})
         begin
            err_count++;
            $display("CHECK FAILED %0t got %h want %h", $time, prdata_o, e[31:0]);
         end
      end
   initial
   begin
      {reset_i, psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = {4'h8, 40'h0};
      repeat (4) @(posedge mclk_i);
      reset_i <= 1'b0;
      d = 9'($urandom(9));
      apb(1'b1, 8'h08, 32'h20);
      apb(1'b1, 8'h0C, 32'h1103);
      i_srm_serial_node.send({1'b0, d[7:0]}, 8, 32, 1'b1);
      chk(irq_o, 1'b1);
      chk(rx_dma_req_o, 1'b1);
      rd(8'h00, SM, 32'h20, 1'b0);
      rd(8'h04, 32'h1FF, {24'h0, d[7:0]}, 1'b0);
      i_srm_serial_node.send(9'h0A5, 8, 32, 1'b1);
      i_srm_serial_node.send(9'h05A, 8, 32, 1'b1);
      rd(8'h00, SM, 32'h28, 1'b0);
      rd(8'h04, 32'h1FF, 32'hA5, 1'b0);
      rd(8'h00, SM, 32'h0, 1'b0);
      i_srm_serial_node.send(9'h0, 8, 32, 1'b0);
      rd(8'h00, SM, 32'h22, 1'b0);
      apb(1'b1, 8'h00, 32'h0);
      rd(8'h00, SM, 32'h2, 1'b0);
      rd(8'h04, 32'h1FF, 32'h0, 1'b0);
      for (k = 0; k < 2; k++)
         for (j = 0; j < 2; j++)
         begin
            apb(1'b1, 8'h0C, {23'h0, 1'b1, j[0], 2'h3, k[0], 4'h3});
            d[8] = ^d[7:0] ^ k[0] ^ j[0];
            i_srm_serial_node.send(d, 9, 32 >> j, 1'b1);
            rd(8'h00, SM, {31'h10, j[0]}, 1'b0);
            rd(8'h04, 32'h1FF, {23'h0, d}, 1'b0);
            d = 9'($urandom);
         end
      apb(1'b1, 8'h40, 32'hFFFFFFFF);
      rd(8'h40, 32'hFFFFFFFF, 32'h0, 1'b1);
      apb(1'b1, 8'h0C, 32'h107);
      i_srm_serial_node.send(9'h033, 8, 32, 1'b1);
      repeat (384) @(posedge mclk_i);
      rd(8'h00, SM, 32'h0, 1'b0);
      rd(8'h0C, 32'h4, 32'h0, 1'b0);
      apb(1'b1, 8'h10, 32'h410);
      apb(1'b1, 8'h0C, 32'h163);
      i_srm_serial_node.send(9'h001, 9, 32, 1'b1);
      rd(8'h00, SM, 32'h21, 1'b0);
      j = 0;
      for (k = 0; k < 96; k++)
      begin
         @(posedge mclk_i);
         j += sc_line_oe_o;
      end
      chk(j == 32, 1'b1);
      chk(pulses == 8, 1'b1);
      test_done;
   end
endmodule

/* tb/srm_serial_node.sv */
// Remote node that sends frames on the receive line.
`timescale 1ns/1ps
module srm_serial_node
(
   input  wire mclk_i,
   output reg  line_o
);
   initial line_o = 1'b1;
   task send(input logic [8:0] dat, input int nb, input int bt, input logic stop);
      int i;
      begin
         @(posedge mclk_i);
         line_o <= 1'b0;
         repeat (bt) @(posedge mclk_i);
         for (i = 0; i < nb; i++)
         begin
            line_o <= dat[i];
            repeat (bt) @(posedge mclk_i);
         end
         line_o <= stop;
         repeat (bt) @(posedge mclk_i);
         line_o <= 1'b1;
      end
   endtask
endmodule
